// ### src/rmw_branch_pkg.sv
// Constants and types for the read-modify-write and relative-branch decoder
// Notes on behaviour
// - The opcode high nibble picks the form (4 accumulator, 5 index, 3 direct, 7 indexed, 6 indexed plus offset) and the low nibble picks negate, invert, shifts, decrement, increment or clear.
// - Low nibble D in every such form is the sign-and-zero test, with the same form selection.
// - Low nibble 9 rotates left and 6 rotates right through carry, carry filling the empty bit and taking the bit shifted out.
// - Accumulator and index forms are 1 byte and 4 cycles, direct 2 and 6, indexed 1 and 6, indexed with offset 2 and 7.
// - Opcode 24 branches on carry clear, and every branch from 20 to 2F is 2 bytes and 4 cycles, taken or not.
// - The unsigned above-or-same and below branches are the same codes as carry clear (24) and carry set (25).
// - Opcode 25 branches on carry set, 2A on negative clear and 2B on negative set.
// - Opcode 22 branches when carry and zero are both clear, 23 when either is set.
// - Opcode 26 branches on zero clear and 27 on zero set.
// - Opcode 28 branches on half carry clear and 29 on half carry set.
// - Opcode 2C branches on interrupt mask clear and 2D on mask set.
// - Opcode 2E branches on the interrupt line low and 2F on it high, using the synchronised line level, not the raw pin.
// - The test operation reads its operand and sets negative and zero but writes nothing back.
// - Every other read-modify-write operation writes its result back to where it read it.
package rmw_branch_pkg;

  // ==========================================================================
  // Opcode fields
  localparam logic [3:0] MODE_ACC     = 4'h4;
  localparam logic [3:0] MODE_IDXREG  = 4'h5;
  localparam logic [3:0] MODE_DIRECT  = 4'h3;
  localparam logic [3:0] MODE_IDX0    = 4'h7;
  localparam logic [3:0] MODE_IDX8    = 4'h6;
  localparam logic [3:0] BRANCH_GROUP = 4'h2;

  localparam logic [3:0] LO_NEGATE  = 4'h0;
  localparam logic [3:0] LO_INVERT  = 4'h3;
  localparam logic [3:0] LO_LSR     = 4'h4;
  localparam logic [3:0] LO_ROR     = 4'h6;
  localparam logic [3:0] LO_ASR     = 4'h7;
  localparam logic [3:0] LO_LSL     = 4'h8;
  localparam logic [3:0] LO_ROL     = 4'h9;
  localparam logic [3:0] LO_DEC     = 4'hA;
  localparam logic [3:0] LO_INC     = 4'hC;
  localparam logic [3:0] LO_TEST    = 4'hD;
  localparam logic [3:0] LO_ZERO    = 4'hF;

  // Branch conditions (low nibble of 2x)
  localparam logic [3:0] BR_ALWAYS    = 4'h0;
  localparam logic [3:0] BR_NEVER     = 4'h1;
  localparam logic [3:0] BR_ABOVE     = 4'h2;
  localparam logic [3:0] BR_BELOW_EQ  = 4'h3;
  localparam logic [3:0] BR_CARRY_CLR = 4'h4;
  localparam logic [3:0] BR_CARRY_SET = 4'h5;
  localparam logic [3:0] BR_NE        = 4'h6;
  localparam logic [3:0] BR_EQ        = 4'h7;
  localparam logic [3:0] BR_HC_CLR    = 4'h8;
  localparam logic [3:0] BR_HC_SET    = 4'h9;
  localparam logic [3:0] BR_PLUS      = 4'hA;
  localparam logic [3:0] BR_MINUS     = 4'hB;
  localparam logic [3:0] BR_MASK_CLR  = 4'hC;
  localparam logic [3:0] BR_MASK_SET  = 4'hD;
  localparam logic [3:0] BR_LINE_LOW  = 4'hE;
  localparam logic [3:0] BR_LINE_HIGH = 4'hF;

  // ==========================================================================
  // Lengths and cycle counts
  localparam logic [1:0] LEN_1      = 2'h1;
  localparam logic [1:0] LEN_2      = 2'h2;
  localparam logic [3:0] CYC_REG    = 4'h4;
  localparam logic [3:0] CYC_DIRECT = 4'h6;
  localparam logic [3:0] CYC_IDX0   = 4'h6;
  localparam logic [3:0] CYC_IDX8   = 4'h7;
  localparam logic [3:0] CYC_BRANCH = 4'h4;

  // ==========================================================================
  // Decoded kinds
  typedef enum logic [3:0] {
    op_none                = 4'h0,
    op_increment           = 4'h1,
    op_decrement           = 4'h2,
    op_zero_fill           = 4'h3,
    op_ones_invert         = 4'h4,
    op_twos_negate         = 4'h5,
    op_rotate_left_carry   = 4'h6,
    op_rotate_right_carry  = 4'h7,
    op_shift_left          = 4'h8,
    op_logical_shift_right = 4'h9,
    op_arith_shift_right   = 4'hA,
    op_sign_zero_test      = 4'hB
  } rmw_op_e;

  typedef enum logic [2:0] {
    mode_none    = 3'h0,
    mode_acc     = 3'h1,
    mode_idxreg  = 3'h2,
    mode_direct  = 3'h3,
    mode_idx0    = 3'h4,
    mode_idx8    = 3'h5,
    mode_rel     = 3'h6
  } addr_mode_e;

endpackage : rmw_branch_pkg

// ### src/branch_condition.sv
// Branch condition evaluator for the 2x opcode row
`timescale 1ns/1ps
`default_nettype none
module branch_condition (
  input  wire logic [3:0] cond,
  input  wire logic       flag_h,
  input  wire logic       flag_i,
  input  wire logic       flag_n,
  input  wire logic       flag_z,
  input  wire logic       flag_c,
  input  wire logic       irq_line,
  output logic            take
);

  // ==========================================================================
  // Condition select
  always_comb
  begin
    case (cond)
      rmw_branch_pkg::BR_ALWAYS:    take = 1'b1;
      rmw_branch_pkg::BR_NEVER:     take = 1'b0;
      rmw_branch_pkg::BR_ABOVE:     take = ~(flag_c | flag_z);
      rmw_branch_pkg::BR_BELOW_EQ:  take = flag_c | flag_z;
      rmw_branch_pkg::BR_CARRY_CLR: take = ~flag_c;
      rmw_branch_pkg::BR_CARRY_SET: take = flag_c;
      rmw_branch_pkg::BR_NE:        take = ~flag_z;
      rmw_branch_pkg::BR_EQ:        take = flag_z;
      rmw_branch_pkg::BR_HC_CLR:    take = ~flag_h;
      rmw_branch_pkg::BR_HC_SET:    take = flag_h;
      rmw_branch_pkg::BR_PLUS:      take = ~flag_n;
      rmw_branch_pkg::BR_MINUS:     take = flag_n;
      rmw_branch_pkg::BR_MASK_CLR:  take = ~flag_i;
      rmw_branch_pkg::BR_MASK_SET:  take = flag_i;
      rmw_branch_pkg::BR_LINE_LOW:  take = ~irq_line;
      rmw_branch_pkg::BR_LINE_HIGH: take = irq_line;
      default:                      take = 1'b0;
    endcase
  end

endmodule : branch_condition
`default_nettype wire

// ### src/rmw_and_branch_decoder.sv
// Registered decoder and operand path for read-modify-write and branch opcodes
`timescale 1ns/1ps
`default_nettype none
module rmw_and_branch_decoder (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        dec_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand,
  input  wire logic [7:0]  rel_offset,
  input  wire logic [15:0] next_pc_in,
  input  wire logic        flag_h,
  input  wire logic        flag_i,
  input  wire logic        flag_n,
  input  wire logic        flag_z,
  input  wire logic        flag_c,
  input  wire logic        irq_pin,
  output logic             out_valid,
  output logic             is_rmw,
  output logic             is_branch,
  output logic [3:0]       op_kind,
  output logic [2:0]       addr_mode,
  output logic [1:0]       inst_bytes,
  output logic [3:0]       inst_cycles,
  output logic [7:0]       result,
  output logic             write_back,
  output logic             new_n,
  output logic             new_z,
  output logic             new_c,
  output logic             c_changed,
  output logic             branch_taken,
  output logic [15:0]      target_pc
);

  // ==========================================================================
  // Interrupt pin synchroniser, three stages
  logic [2:0] irq_sync;
  logic       irq_level;
  logic [2:0] next_irq_sync;
  logic       next_irq_level;

  // Pin is asynchronous, so the level moves only when stages two and three agree
  always_comb
  begin
    next_irq_sync  = {irq_sync[1:0], irq_pin};
    next_irq_level = (irq_sync[1] == irq_sync[2]) ? irq_sync[2] : irq_level;
  end

  // Register the stages; reset leaves the level low
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_sync  <= 3'h0;
      irq_level <= 1'b0;
    end
    else
    begin
      irq_sync  <= next_irq_sync;
      irq_level <= next_irq_level;
    end
  end

  // ==========================================================================
  // Shared helpers
  // Low nibble to operation
  function automatic rmw_branch_pkg::rmw_op_e lo_to_op(input logic [3:0] lo);
    case (lo)
      rmw_branch_pkg::LO_NEGATE: lo_to_op = rmw_branch_pkg::op_twos_negate;
      rmw_branch_pkg::LO_INVERT: lo_to_op = rmw_branch_pkg::op_ones_invert;
      rmw_branch_pkg::LO_LSR:    lo_to_op = rmw_branch_pkg::op_logical_shift_right;
      rmw_branch_pkg::LO_ROR:    lo_to_op = rmw_branch_pkg::op_rotate_right_carry;
      rmw_branch_pkg::LO_ASR:    lo_to_op = rmw_branch_pkg::op_arith_shift_right;
      rmw_branch_pkg::LO_LSL:    lo_to_op = rmw_branch_pkg::op_shift_left;
      rmw_branch_pkg::LO_ROL:    lo_to_op = rmw_branch_pkg::op_rotate_left_carry;
      rmw_branch_pkg::LO_DEC:    lo_to_op = rmw_branch_pkg::op_decrement;
      rmw_branch_pkg::LO_INC:    lo_to_op = rmw_branch_pkg::op_increment;
      rmw_branch_pkg::LO_TEST:   lo_to_op = rmw_branch_pkg::op_sign_zero_test;
      rmw_branch_pkg::LO_ZERO:   lo_to_op = rmw_branch_pkg::op_zero_fill;
      default:                   lo_to_op = rmw_branch_pkg::op_none;
    endcase
  endfunction : lo_to_op

  // High nibble to addressing form
  // Row 2 is the relative branch group
  function automatic rmw_branch_pkg::addr_mode_e hi_to_mode(input logic [3:0] hi);
    case (hi)
      rmw_branch_pkg::MODE_ACC:     hi_to_mode = rmw_branch_pkg::mode_acc;
      rmw_branch_pkg::MODE_IDXREG:  hi_to_mode = rmw_branch_pkg::mode_idxreg;
      rmw_branch_pkg::MODE_DIRECT:  hi_to_mode = rmw_branch_pkg::mode_direct;
      rmw_branch_pkg::MODE_IDX0:    hi_to_mode = rmw_branch_pkg::mode_idx0;
      rmw_branch_pkg::MODE_IDX8:    hi_to_mode = rmw_branch_pkg::mode_idx8;
      rmw_branch_pkg::BRANCH_GROUP: hi_to_mode = rmw_branch_pkg::mode_rel;
      default:                      hi_to_mode = rmw_branch_pkg::mode_none;
    endcase
  endfunction : hi_to_mode

  // ==========================================================================
  // Branch condition
  logic cond_take;

  // Condition sees the synchronised line, not the raw pin
  branch_condition u_cond (
    .cond     (opcode[3:0]),
    .flag_h   (flag_h),
    .flag_i   (flag_i),
    .flag_n   (flag_n),
    .flag_z   (flag_z),
    .flag_c   (flag_c),
    .irq_line (irq_level),
    .take     (cond_take)
  );

  // ==========================================================================
  // Decode and execute next values
  rmw_branch_pkg::rmw_op_e    dec_op;
  rmw_branch_pkg::addr_mode_e dec_mode;
  logic                       dec_rmw;
  logic                       dec_branch;
  logic                       next_out_valid;
  logic                       next_is_rmw;
  logic                       next_is_branch;
  logic [3:0]                 next_op_kind;
  logic [2:0]                 next_addr_mode;
  logic [1:0]                 next_inst_bytes;
  logic [3:0]                 next_inst_cycles;
  logic [7:0]                 next_result;
  logic                       next_write_back;
  logic                       next_new_c;
  logic                       next_c_changed;
  logic                       next_branch_taken;
  logic [15:0]                next_target_pc;
  logic                       next_new_n;
  logic                       next_new_z;

  // Next value of every output
  always_comb
  begin
    dec_mode   = hi_to_mode(opcode[7:4]);
    dec_op     = lo_to_op(opcode[3:0]);
    dec_branch = dec_valid && (dec_mode == rmw_branch_pkg::mode_rel);
    dec_rmw    = dec_valid && (dec_mode != rmw_branch_pkg::mode_rel)
                 && (dec_mode != rmw_branch_pkg::mode_none)
                 && (dec_op != rmw_branch_pkg::op_none);
    next_out_valid    = dec_rmw || dec_branch;
    next_is_rmw       = dec_rmw;
    next_is_branch    = dec_branch;
    next_op_kind      = dec_rmw ? dec_op : rmw_branch_pkg::op_none;
    next_addr_mode    = next_out_valid ? dec_mode : rmw_branch_pkg::mode_none;
    next_inst_bytes   = 2'h0;
    next_inst_cycles  = 4'h0;
    next_result       = operand;
    next_new_c        = flag_c;
    next_c_changed    = 1'b0;
    next_write_back   = dec_rmw && (dec_op != rmw_branch_pkg::op_sign_zero_test);
    next_branch_taken = dec_branch && cond_take;
    next_target_pc    = next_pc_in;
    // Length and time per form
    case (next_addr_mode)
      rmw_branch_pkg::mode_acc,
      rmw_branch_pkg::mode_idxreg:
      begin
        next_inst_bytes  = rmw_branch_pkg::LEN_1;
        next_inst_cycles = rmw_branch_pkg::CYC_REG;
      end
      rmw_branch_pkg::mode_direct:
      begin
        next_inst_bytes  = rmw_branch_pkg::LEN_2;
        next_inst_cycles = rmw_branch_pkg::CYC_DIRECT;
      end
      rmw_branch_pkg::mode_idx0:
      begin
        next_inst_bytes  = rmw_branch_pkg::LEN_1;
        next_inst_cycles = rmw_branch_pkg::CYC_IDX0;
      end
      rmw_branch_pkg::mode_idx8:
      begin
        next_inst_bytes  = rmw_branch_pkg::LEN_2;
        next_inst_cycles = rmw_branch_pkg::CYC_IDX8;
      end
      rmw_branch_pkg::mode_rel:
      begin
        next_inst_bytes  = rmw_branch_pkg::LEN_2;
        next_inst_cycles = rmw_branch_pkg::CYC_BRANCH;
      end
      default:
      begin
        next_inst_bytes  = 2'h0;
        next_inst_cycles = 4'h0;
      end
    endcase
    // Operand modification
    case (next_op_kind)
      rmw_branch_pkg::op_increment:  next_result = operand + 8'h01;
      rmw_branch_pkg::op_decrement:  next_result = operand - 8'h01;
      rmw_branch_pkg::op_zero_fill:
      begin
        next_result    = 8'h00;
        next_new_c     = 1'b0;
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_ones_invert:
      begin
        next_result    = ~operand;
        next_new_c     = 1'b1;
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_twos_negate:
      begin
        next_result    = 8'h00 - operand;
        next_new_c     = (operand != 8'h00);
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_rotate_left_carry:
      begin
        next_result    = {operand[6:0], flag_c};
        next_new_c     = operand[7];
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_rotate_right_carry:
      begin
        next_result    = {flag_c, operand[7:1]};
        next_new_c     = operand[0];
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_shift_left:
      begin
        next_result    = {operand[6:0], 1'b0};
        next_new_c     = operand[7];
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_logical_shift_right:
      begin
        next_result    = {1'b0, operand[7:1]};
        next_new_c     = operand[0];
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_arith_shift_right:
      begin
        next_result    = {operand[7], operand[7:1]};
        next_new_c     = operand[0];
        next_c_changed = 1'b1;
      end
      rmw_branch_pkg::op_sign_zero_test: next_result = operand;
      default:                            next_result = operand;
    endcase
    // Relative target
    if (next_branch_taken)
    begin
      next_target_pc = next_pc_in + {{8{rel_offset[7]}}, rel_offset};
    end
    // Result flags, only meaningful for read-modify-write
    next_new_n = next_result[7];
    next_new_z = (next_result == 8'h00);
  end

  // ==========================================================================
  // Output registers
  // Every output is recomputed at each edge and stands one cycle
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_valid    <= 1'b0;
      is_rmw       <= 1'b0;
      is_branch    <= 1'b0;
      op_kind      <= 4'h0;
      addr_mode    <= 3'h0;
      inst_bytes   <= 2'h0;
      inst_cycles  <= 4'h0;
      result       <= 8'h00;
      write_back   <= 1'b0;
      new_n        <= 1'b0;
      new_z        <= 1'b0;
      new_c        <= 1'b0;
      c_changed    <= 1'b0;
      branch_taken <= 1'b0;
      target_pc    <= 16'h0000;
    end
    else
    begin
      out_valid    <= next_out_valid;
      is_rmw       <= next_is_rmw;
      is_branch    <= next_is_branch;
      op_kind      <= next_op_kind;
      addr_mode    <= next_addr_mode;
      inst_bytes   <= next_inst_bytes;
      inst_cycles  <= next_inst_cycles;
      result       <= next_result;
      write_back   <= next_write_back;
      new_n        <= next_new_n;
      new_z        <= next_new_z;
      new_c        <= next_new_c;
      c_changed    <= next_c_changed;
      branch_taken <= next_branch_taken;
      target_pc    <= next_target_pc;
    end
  end

endmodule : rmw_and_branch_decoder
`default_nettype wire

// ### tb/rmw_and_branch_decoder_props.sv
// Checker for the decoder's registered outputs
`timescale 1ns/1ps
`default_nettype none
module rmw_and_branch_decoder_props (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        dec_valid,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand,
  input wire logic [7:0]  rel_offset,
  input wire logic [15:0] next_pc_in,
  input wire logic        flag_z,
  input wire logic        flag_c,
  input wire logic        is_branch,
  input wire logic [3:0]  op_kind,
  input wire logic [2:0]  addr_mode,
  input wire logic [1:0]  inst_bytes,
  input wire logic [3:0]  inst_cycles,
  input wire logic [7:0]  result,
  input wire logic        write_back,
  input wire logic        branch_taken,
  input wire logic [15:0] target_pc
);
  // ==========================================================================
  // Request classes
  logic rmw_req;
  logic br_req;
  assign rmw_req = dec_valid && opcode[7:4] inside {[4'h3:4'h7]}
                   && opcode[3:0] inside {4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hF};
  assign br_req  = dec_valid && opcode[7:4] == 4'h2;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Assertions
  a_reg_timing: assert property (
    rmw_req && opcode[7:4] inside {4'h4, 4'h5} |=> inst_bytes == 2'h1 && inst_cycles == 4'h4)
    else $error("register form length or time wrong");
  a_direct_form: assert property (
    rmw_req && opcode[7:4] == 4'h3 |=> addr_mode == 3'h3 && inst_bytes == 2'h2 && inst_cycles == 4'h6)
    else $error("direct form decode wrong");
  a_offset_form: assert property (
    rmw_req && opcode[7:4] == 4'h6 |=> addr_mode == 3'h5 && inst_bytes == 2'h2 && inst_cycles == 4'h7)
    else $error("offset form decode wrong");
  a_plain_index: assert property (
    rmw_req && opcode[7:4] == 4'h7 |=> addr_mode == 3'h4 && inst_bytes == 2'h1 && inst_cycles == 4'h6)
    else $error("indexed form decode wrong");
  a_branch_form: assert property (
    br_req |=> is_branch && op_kind == 4'h0 && inst_bytes == 2'h2 && inst_cycles == 4'h4)
    else $error("branch length or time wrong");
  a_test_nowrite: assert property (
    rmw_req && opcode[3:0] == 4'hD |=> op_kind == 4'hB && !write_back && result == $past(operand))
    else $error("test operation wrote back");
  a_rmw_write: assert property (
    rmw_req && opcode[3:0] != 4'hD |=> write_back)
    else $error("modify without write back");
  a_carry_branch: assert property (
    dec_valid && opcode inside {8'h24, 8'h25} |=> branch_taken == ($past(flag_c) == $past(opcode[0])))
    else $error("carry branch decision wrong");
  a_above_branch: assert property (
    dec_valid && opcode == 8'h22 |=> branch_taken == !($past(flag_c) || $past(flag_z)))
    else $error("above branch decision wrong");
  a_target_pc: assert property (
    br_req |=> target_pc == (branch_taken ? $past(next_pc_in) + 16'($signed($past(rel_offset)))
                                          : $past(next_pc_in)))
    else $error("branch target wrong");

  // Main scenarios seen
  c_taken_branch: cover property (br_req ##1 branch_taken);
  c_test_op: cover property (rmw_req && opcode[3:0] == 4'hD);
  c_offset_form: cover property (rmw_req && opcode[7:4] == 4'h6);
endmodule : rmw_and_branch_decoder_props

bind rmw_and_branch_decoder rmw_and_branch_decoder_props u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .dec_valid(dec_valid), .opcode(opcode), .operand(operand),
  .rel_offset(rel_offset), .next_pc_in(next_pc_in), .flag_z(flag_z), .flag_c(flag_c),
  .is_branch(is_branch), .op_kind(op_kind), .addr_mode(addr_mode), .inst_bytes(inst_bytes),
  .inst_cycles(inst_cycles), .result(result), .write_back(write_back), .branch_taken(branch_taken),
  .target_pc(target_pc)
);
`default_nettype wire

// ### tb/rmw_and_branch_decoder_test.sv
// Self-checking testbench for the decoder
`timescale 1ns/1ps
`default_nettype none
module rmw_and_branch_decoder_test;
  typedef struct packed {
    logic vld; logic rmw; logic br; logic [3:0] kind; logic [2:0] mode; logic [1:0] nb; logic [3:0] ncyc;
    logic [7:0] res; logic wb; logic n; logic z; logic c; logic cchg; logic tk; logic [15:0] tgt;
  } exp_s;
  logic        ref_clk = 1'b0;
  logic        sys_rst, dec_valid, flag_h, flag_i, flag_n, flag_z, flag_c, irq_pin, irq_lvl;
  logic [7:0]  opcode, operand, rel_offset, result;
  logic [15:0] next_pc_in, target_pc;
  logic        out_valid, is_rmw, is_branch, write_back, new_n, new_z, new_c, c_changed, branch_taken;
  logic [3:0]  op_kind, inst_cycles;
  logic [2:0]  addr_mode;
  logic [1:0]  inst_bytes;
  logic [31:0] seed = 32'h990BB3C6;
  logic [7:0]  corner [5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};
  int          n_mismatch = 0;
  int          n_checks = 0;

  // Clock, 4 ns period
  always #2 ref_clk = ~ref_clk;

  rmw_and_branch_decoder dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .dec_valid(dec_valid), .opcode(opcode), .operand(operand),
    .rel_offset(rel_offset), .next_pc_in(next_pc_in), .flag_h(flag_h), .flag_i(flag_i), .flag_n(flag_n),
    .flag_z(flag_z), .flag_c(flag_c), .irq_pin(irq_pin), .out_valid(out_valid), .is_rmw(is_rmw),
    .is_branch(is_branch), .op_kind(op_kind), .addr_mode(addr_mode), .inst_bytes(inst_bytes),
    .inst_cycles(inst_cycles), .result(result), .write_back(write_back), .new_n(new_n), .new_z(new_z),
    .new_c(new_c), .c_changed(c_changed), .branch_taken(branch_taken), .target_pc(target_pc)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xorshift

  // Expected outputs; f is {h, i, n, z, c}
  function automatic exp_s predict(input logic [7:0] op, input logic [7:0] x, input logic [7:0] off,
                                   input logic [15:0] pc, input logic [4:0] f);
    exp_s        e;
    logic [15:0] conds;
    e = '0;
    e.res = x;
    e.tgt = pc;
    e.c = f[0];
    conds = {irq_lvl, !irq_lvl, f[3], !f[3], f[2], !f[2], f[4], !f[4], f[1], !f[1], f[0], !f[0],
             f[0] | f[1], !(f[0] | f[1]), 1'b0, 1'b1};
    if (op[7:4] == 4'h2)
    begin
      {e.vld, e.br, e.mode, e.nb, e.ncyc} = {2'b11, 3'h6, 2'h2, 4'h4};
      e.tk = conds[op[3:0]];
      if (e.tk)
        e.tgt = pc + {{8{off[7]}}, off};
    end
    else if (op[7:4] inside {[4'h3:4'h7]} && op[3:0] inside {4'h0, 4'h3, 4'h4, [4'h6:4'hA], 4'hC, 4'hD, 4'hF})
    begin
      {e.vld, e.rmw, e.wb} = {2'b11, op[3:0] != 4'hD};
      e.cchg = !(op[3:0] inside {4'hA, 4'hC, 4'hD});
      case (op[7:4])
        4'h4: {e.mode, e.nb, e.ncyc} = {3'h1, 2'h1, 4'h4};
        4'h5: {e.mode, e.nb, e.ncyc} = {3'h2, 2'h1, 4'h4};
        4'h3: {e.mode, e.nb, e.ncyc} = {3'h3, 2'h2, 4'h6};
        4'h7: {e.mode, e.nb, e.ncyc} = {3'h4, 2'h1, 4'h6};
        default: {e.mode, e.nb, e.ncyc} = {3'h5, 2'h2, 4'h7};
      endcase
      case (op[3:0])
        4'h0: {e.kind, e.res, e.c} = {4'h5, 8'h00 - x, x != 8'h00};
        4'h3: {e.kind, e.res, e.c} = {4'h4, ~x, 1'b1};
        4'h4: {e.kind, e.res, e.c} = {4'h9, 1'b0, x[7:1], x[0]};
        4'h6: {e.kind, e.res, e.c} = {4'h7, f[0], x[7:1], x[0]};
        4'h7: {e.kind, e.res, e.c} = {4'hA, x[7], x[7:1], x[0]};
        4'h8: {e.kind, e.res, e.c} = {4'h8, x[6:0], 1'b0, x[7]};
        4'h9: {e.kind, e.res, e.c} = {4'h6, x[6:0], f[0], x[7]};
        4'hA: {e.kind, e.res} = {4'h2, x - 8'h01};
        4'hC: {e.kind, e.res} = {4'h1, x + 8'h01};
        4'hD: e.kind = 4'hB;
        default: {e.kind, e.res, e.c} = {4'h3, 8'h00, 1'b0};
      endcase
      {e.n, e.z} = {e.res[7], e.res == 8'h00};
    end
    return e;
  endfunction : predict

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  // Drive one request at the falling edge, compare one cycle later
  task automatic run_op(input logic v, input logic [7:0] op, input logic [7:0] x, input logic [7:0] off,
                        input logic [15:0] pc, input logic [4:0] f);
    exp_s e;
    {dec_valid, opcode, operand, rel_offset, next_pc_in} = {v, op, x, off, pc};
    {flag_h, flag_i, flag_n, flag_z, flag_c} = f;
    e = predict(v ? op : 8'h00, x, off, pc, f);
    @(negedge ref_clk);
    chk(out_valid, e.vld);
    chk(is_rmw, e.rmw);
    chk(is_branch, e.br);
    chk(op_kind, e.kind);
    chk(addr_mode, e.mode);
    chk(inst_bytes, e.nb);
    chk(inst_cycles, e.ncyc);
    chk(write_back, e.wb);
    chk(branch_taken, e.tk);
    chk(target_pc, e.tgt);
    if (!e.br)
      chk(result, e.res);
    if (e.rmw)
    begin
      chk(new_n, e.n);
      chk(new_z, e.z);
      chk(new_c, e.c);
      chk(c_changed, e.cchg);
    end
  endtask : run_op

  task automatic give_verdict();
    $display("TB: checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Tests
  initial
  begin
    {sys_rst, dec_valid, opcode, operand, rel_offset, next_pc_in} = {1'b1, 41'h0};
    {flag_h, flag_i, flag_n, flag_z, flag_c, irq_pin, irq_lvl} = 7'h00;
    repeat (2) @(negedge ref_clk);
    chk(out_valid, 1'b0);
    sys_rst = 1'b0;
    run_op(1'b1, 8'h4C, 8'h7F, 8'h00, 16'h0000, 5'h00);
    run_op(1'b1, 8'h27, 8'h00, 8'hFE, 16'h0102, 5'h02);
    run_op(1'b1, 8'h20, 8'h00, 8'h01, 16'hFFFF, 5'h00);
    $display("TB: walk test done");
    for (int hv = 3; hv <= 7; hv++)
      for (int lv = 0; lv < 16; lv++)
        for (int k = 0; k < 10; k++)
          run_op(1'b1, {hv[3:0], lv[3:0]}, corner[k % 5], 8'h00, 16'h1000, {4'h0, k[0]});
    $display("TB: form test done");
    for (int lv = 0; lv < 16; lv++)
      for (int fv = 0; fv < 32; fv++)
        run_op(1'b1, {4'h2, lv[3:0]}, 8'h00, 8'(fv * 8), 16'h8000 - 16'(fv), fv[4:0]);
    $display("TB: branch test done");
    for (int k = 0; k < 1500; k++)
    begin
      seed = xorshift(seed);
      run_op(seed[30] | seed[29], seed[31] ? seed[7:0] : {4'h2 + ({1'b0, seed[10:8]} % 4'h6), seed[3:0]},
             seed[23:16], seed[15:8], seed[31:16], seed[28:24]);
    end
    $display("TB: random test done");
    dec_valid = 1'b0;
    irq_pin = 1'b1;
    repeat (5) @(negedge ref_clk);
    irq_lvl = 1'b1;
    run_op(1'b1, 8'h2F, 8'h00, 8'h10, 16'h0200, 5'h00);
    run_op(1'b1, 8'h2E, 8'h00, 8'h10, 16'h0200, 5'h00);
    dec_valid = 1'b0;
    irq_pin = 1'b0;
    repeat (5) @(negedge ref_clk);
    irq_lvl = 1'b0;
    run_op(1'b1, 8'h2E, 8'h00, 8'h80, 16'h0200, 5'h00);
    run_op(1'b1, 8'h2F, 8'h00, 8'h80, 16'h0200, 5'h00);
    $display("TB: interrupt line test done");
    sys_rst = 1'b1;
    #1;
    chk(out_valid, 1'b0);
    chk(branch_taken, 1'b0);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    run_op(1'b1, 8'h6D, 8'h80, 8'h00, 16'h0000, 5'h01);
    $display("TB: reset test done");
    give_verdict();
  end

  // Watchdog well past the expected run time
  initial
  begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule : rmw_and_branch_decoder_test
`default_nettype wire
